// ### design/packed_unsigned_simd_alu.sv
// packed_unsigned_simd_alu: one-cycle packed unsigned datapath slice
// assumes the pipeline drives a decoded op with a valid strobe on clk
`timescale 1ns/1ps
module packed_unsigned_simd_alu (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  op_valid,
   input  wire simd_alu_pkg::op_e     op,
   input  wire logic [31:0]           first_operand_reg,
   input  wire logic [31:0]           second_operand_reg,
   input  wire logic [31:0]           accumulate_reg,
   input  wire logic [3:0]            first_operand_num,
   input  wire logic [3:0]            second_operand_num,
   input  wire logic [3:0]            accumulate_num,
   input  wire logic                  dest_present,
   input  wire logic [3:0]            dest_num,
   input  wire logic [3:0]            greater_equal_flags,
   output logic                       result_valid,
   output logic [31:0]                result,
   output logic [3:0]                 result_dest_num,
   output logic                       flags_write,
   output logic                       illegal_reg
);
   lane_if lanes ();

   logic        rst_meta_q;
   logic        rst_sync_q;
   logic        valid_q;
   logic [31:0] result_q;
   logic [31:0] result_d;
   logic [3:0]  dest_q;
   logic        illegal_q;
   logic [3:0]  dest_d;
   logic [31:0] select_bytes;
   logic        uses_acc;
   logic        bad_num;
   logic        illegal_d;

   // only the registered copy of reset reaches the datapath
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign lanes.first_operand  = first_operand_reg;
   assign lanes.second_operand = second_operand_reg;

   lane_unit u_lanes (
      .lanes (lanes.unit)
   );

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sel
         assign select_bytes[8*g +: 8] = greater_equal_flags[g]
                                       ? first_operand_reg[8*g +: 8]
                                       : second_operand_reg[8*g +: 8];
      end
   endgenerate

   assign dest_d   = dest_present ? dest_num : first_operand_num;
   assign uses_acc = (op == simd_alu_pkg::OP_SUM_ABS_DIFF_ACCUMULATE);
   // the source is trusted; a violation is only reported (never for byte select), result still written
   assign bad_num  = (first_operand_num == simd_alu_pkg::STACK_POINTER_NUM)
                   || (first_operand_num == simd_alu_pkg::PROGRAM_COUNTER_NUM)
                   || (second_operand_num == simd_alu_pkg::STACK_POINTER_NUM)
                   || (second_operand_num == simd_alu_pkg::PROGRAM_COUNTER_NUM)
                   || (dest_d == simd_alu_pkg::STACK_POINTER_NUM)
                   || (dest_d == simd_alu_pkg::PROGRAM_COUNTER_NUM)
                   || (uses_acc && (accumulate_num == simd_alu_pkg::STACK_POINTER_NUM
                                  || accumulate_num == simd_alu_pkg::PROGRAM_COUNTER_NUM));
   assign illegal_d = op_valid && bad_num && (op != simd_alu_pkg::OP_BYTE_SELECT);

   always_comb begin
      unique case (op)
         simd_alu_pkg::OP_HALVING_ADD_SUB_EXCHANGE: result_d = lanes.halving_asx;
         simd_alu_pkg::OP_HALVING_SUB_ADD_EXCHANGE: result_d = lanes.halving_sax;
         simd_alu_pkg::OP_HALVING_SUB_HALFWORDS:    result_d = lanes.halving_sub16;
         simd_alu_pkg::OP_HALVING_SUB_BYTES:        result_d = lanes.halving_sub8;
         simd_alu_pkg::OP_BYTE_SELECT:              result_d = select_bytes;
         simd_alu_pkg::OP_SUM_ABS_DIFF_BYTES:       result_d = lanes.sad_sum;
         simd_alu_pkg::OP_SUM_ABS_DIFF_ACCUMULATE:
            result_d = lanes.sad_sum + accumulate_reg;
         simd_alu_pkg::OP_UNSIGNED_SUB_HALFWORDS:   result_d = lanes.plain_sub16;
         simd_alu_pkg::OP_UNSIGNED_SUB_BYTES:       result_d = lanes.plain_sub8;
         default:                                   result_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         valid_q   <= 1'b0;
         result_q  <= 32'h00000000;
         dest_q    <= 4'h0;
         illegal_q <= 1'b0;
      end else begin
         valid_q   <= op_valid;
         illegal_q <= illegal_d;
         if (op_valid) begin
            result_q <= result_d;
            dest_q   <= dest_d;
         end
      end
   end

   assign result_valid    = valid_q;
   assign result          = result_q;
   assign result_dest_num = dest_q;
   // none of these operations ever touch status flags
   assign flags_write     = 1'b0;
   assign illegal_reg     = illegal_q;

   // helper: reference absolute-difference sum
   logic [31:0] ref_sad;
   always_comb begin
      ref_sad = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         if (first_operand_reg[8*i +: 8] >= second_operand_reg[8*i +: 8])
            ref_sad = ref_sad + 32'(first_operand_reg[8*i +: 8] - second_operand_reg[8*i +: 8]);
         else
            ref_sad = ref_sad + 32'(second_operand_reg[8*i +: 8] - first_operand_reg[8*i +: 8]);
      end
   end

   property p_asx_upper;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_HALVING_ADD_SUB_EXCHANGE |=> result[31:16] ==
         16'(({1'b0, $past(first_operand_reg[31:16])} + {1'b0, $past(second_operand_reg[15:0])}) >> 1);
   endproperty
   a_asx_upper: assert property (p_asx_upper) else $error("asx upper wrong");

   property p_asx_lower;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_HALVING_ADD_SUB_EXCHANGE |=> result[15:0] ==
         16'(({1'b0, $past(first_operand_reg[15:0])} - {1'b0, $past(second_operand_reg[31:16])}) >> 1);
   endproperty
   a_asx_lower: assert property (p_asx_lower) else $error("asx lower wrong");

   property p_sax_upper;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_HALVING_SUB_ADD_EXCHANGE |=> result[31:16] ==
         16'(({1'b0, $past(first_operand_reg[31:16])} - {1'b0, $past(second_operand_reg[15:0])}) >> 1);
   endproperty
   a_sax_upper: assert property (p_sax_upper) else $error("sax upper wrong");

   property p_sax_lower;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_HALVING_SUB_ADD_EXCHANGE |=> result[15:0] ==
         16'(({1'b0, $past(first_operand_reg[15:0])} + {1'b0, $past(second_operand_reg[31:16])}) >> 1);
   endproperty
   a_sax_lower: assert property (p_sax_lower) else $error("sax lower wrong");

   property p_no_flags;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid |-> ##1 !flags_write [*2];
   endproperty
   a_no_flags: assert property (p_no_flags) else $error("flags written");

   property p_select;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_BYTE_SELECT && greater_equal_flags == 4'h5 |=>
         result == {$past(second_operand_reg[31:24]), $past(first_operand_reg[23:16]),
                    $past(second_operand_reg[15:8]), $past(first_operand_reg[7:0])};
   endproperty
   a_select: assert property (p_select) else $error("byte select wrong");

   property p_sad;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_SUM_ABS_DIFF_BYTES |=> result == $past(ref_sad);
   endproperty
   a_sad: assert property (p_sad) else $error("abs diff sum wrong");

   property p_sada;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_SUM_ABS_DIFF_ACCUMULATE |=>
         result == $past(ref_sad) + $past(accumulate_reg);
   endproperty
   a_sada: assert property (p_sada) else $error("accumulate sum wrong");

   property p_sub16;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && op == simd_alu_pkg::OP_UNSIGNED_SUB_HALFWORDS |=> result[15:0] ==
         16'($past(first_operand_reg[15:0]) - $past(second_operand_reg[15:0]));
   endproperty
   a_sub16: assert property (p_sub16) else $error("halfword sub wrong");

   property p_dest;
      @(posedge clk) disable iff (!rst_sync_q)
      op_valid && !dest_present |=> result_valid && result_dest_num == $past(first_operand_num);
   endproperty
   a_dest: assert property (p_dest) else $error("default destination wrong");
endmodule // packed_unsigned_simd_alu

// ### design/simd_alu_pkg.sv
// simd_alu_pkg: opcodes, lane widths and register numbers for the packed alu
// assumes a decoded opcode and register numbers arrive from the pipeline
package simd_alu_pkg;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned HALF_W   = 16;
   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned N_HALF   = 2;
   localparam int unsigned N_BYTE   = 4;
   localparam int unsigned REG_W    = 4;
   localparam int unsigned GE_W     = 4;
   localparam logic [3:0]  STACK_POINTER_NUM   = 4'hd;
   localparam logic [3:0]  PROGRAM_COUNTER_NUM = 4'hf;

   typedef enum logic [3:0] {
      OP_HALVING_ADD_SUB_EXCHANGE,
      OP_HALVING_SUB_ADD_EXCHANGE,
      OP_HALVING_SUB_HALFWORDS,
      OP_HALVING_SUB_BYTES,
      OP_BYTE_SELECT,
      OP_SUM_ABS_DIFF_BYTES,
      OP_SUM_ABS_DIFF_ACCUMULATE,
      OP_UNSIGNED_SUB_HALFWORDS,
      OP_UNSIGNED_SUB_BYTES
   } op_e;
endpackage

// ### design/lane_if.sv
// lane_if: operands in, per-lane results out, between top and lane unit
// assumes both ends share one clock; purely combinational content
`timescale 1ns/1ps
interface lane_if;
   logic [31:0] first_operand;
   logic [31:0] second_operand;
   logic [31:0] halving_asx;
   logic [31:0] halving_sax;
   logic [31:0] halving_sub16;
   logic [31:0] halving_sub8;
   logic [31:0] plain_sub16;
   logic [31:0] plain_sub8;
   logic [31:0] sad_sum;
   modport top  (output first_operand, output second_operand, input halving_asx,
                 input halving_sax, input halving_sub16, input halving_sub8,
                 input plain_sub16, input plain_sub8, input sad_sum);
   modport unit (input first_operand, input second_operand, output halving_asx,
                 output halving_sax, output halving_sub16, output halving_sub8,
                 output plain_sub16, output plain_sub8, output sad_sum);
endinterface

// ### design/lane_unit.sv
// lane_unit: combinational lane arithmetic for the packed operations; byte select and the accumulate add are done in the top
// assumes operands are stable within a cycle; result capture is done by the top
`timescale 1ns/1ps
module lane_unit (
   lane_if.unit lanes
);
   logic [15:0] a_hi;
   logic [15:0] a_lo;
   logic [15:0] b_hi;
   logic [15:0] b_lo;
   logic [16:0] asx_sum;
   logic [16:0] asx_dif;
   logic [16:0] sax_dif;
   logic [16:0] sax_sum;
   logic [9:0]  abs_w [4];

   assign a_hi = lanes.first_operand[31:16];
   assign a_lo = lanes.first_operand[15:0];
   assign b_hi = lanes.second_operand[31:16];
   assign b_lo = lanes.second_operand[15:0];

   // 17-bit sums keep carry and borrow for the halving shift
   assign asx_sum = {1'b0, a_hi} + {1'b0, b_lo};
   assign asx_dif = {1'b0, a_lo} - {1'b0, b_hi};
   assign sax_dif = {1'b0, a_hi} - {1'b0, b_lo};
   assign sax_sum = {1'b0, a_lo} + {1'b0, b_hi};
   assign lanes.halving_asx = {asx_sum[16:1], asx_dif[16:1]};
   assign lanes.halving_sax = {sax_dif[16:1], sax_sum[16:1]};

   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : g_half
         logic [16:0] d;
         assign d = {1'b0, lanes.first_operand[16*h +: 16]}
                  - {1'b0, lanes.second_operand[16*h +: 16]};
         assign lanes.halving_sub16[16*h +: 16] = d[16:1];
         assign lanes.plain_sub16[16*h +: 16]   = d[15:0];
      end
   endgenerate

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_byte
         logic [8:0] d;
         logic [7:0] mag;
         assign d = {1'b0, lanes.first_operand[8*b +: 8]}
                  - {1'b0, lanes.second_operand[8*b +: 8]};
         assign lanes.halving_sub8[8*b +: 8] = d[8:1];
         assign lanes.plain_sub8[8*b +: 8]   = d[7:0];
         // borrow bit tells which way round the magnitude lies
         assign mag = d[8] ? 8'(~d[7:0] + 8'h01) : d[7:0];
         assign abs_w[b] = {2'b00, mag};
      end
   endgenerate

   assign lanes.sad_sum = {22'h0, abs_w[0] + abs_w[1] + abs_w[2] + abs_w[3]};
endmodule // lane_unit

// ### bench/pipeline_model.sv
// pipeline_model: issuing stage that feeds decoded packed ops to the alu
// assumes one shared clock; the caller steps it through send, idle and park
`timescale 1ns/1ps
module pipeline_model (
   input  wire logic         clk,
   output logic              op_valid,
   output simd_alu_pkg::op_e op,
   output logic [31:0]       first_operand_reg,
   output logic [31:0]       second_operand_reg,
   output logic [31:0]       accumulate_reg,
   output logic [3:0]        first_operand_num,
   output logic [3:0]        second_operand_num,
   output logic [3:0]        accumulate_num,
   output logic              dest_present,
   output logic [3:0]        dest_num,
   output logic [3:0]        greater_equal_flags
);
   logic [31:0] idle_pat = 32'ha5c3_3c5a;

   // idle buses keep moving: a stale operand could hide a missing capture
   task automatic park();
      idle_pat = ~idle_pat;
      op_valid <= 1'b0;
      op <= simd_alu_pkg::op_e'(idle_pat[1:0]);
      first_operand_reg <= idle_pat;
      second_operand_reg <= ~idle_pat;
      accumulate_reg <= idle_pat;
      {first_operand_num, second_operand_num, accumulate_num, dest_num} <= idle_pat[15:0];
      dest_present <= idle_pat[16];
      greater_equal_flags <= idle_pat[23:20];
   endtask

   task automatic send(input simd_alu_pkg::op_e o, input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] c, input logic [3:0] g, input logic [15:0] nums,
                       input logic dp);
      @(posedge clk);
      op_valid <= 1'b1;
      op <= o;
      first_operand_reg <= a;
      second_operand_reg <= b;
      accumulate_reg <= c;
      greater_equal_flags <= g;
      dest_present <= dp;
      // 13 and 15 only when a scenario wants the flag
      {first_operand_num, second_operand_num, accumulate_num, dest_num} <= nums;
   endtask

   task automatic idle();
      @(posedge clk);
      park();
   endtask
endmodule // pipeline_model

// ### bench/tb_packed_unsigned_simd_alu.sv
// tb_packed_unsigned_simd_alu: self-checking bench for the packed alu
// assumes pipeline_model drives every alu input except clk and rst_b
`timescale 1ns/1ps
module tb_packed_unsigned_simd_alu;
   logic              clk;
   logic              rst_b;
   logic              op_valid, dest_present, result_valid, flags_write, illegal_reg;
   simd_alu_pkg::op_e op;
   logic [31:0]       first_operand_reg, second_operand_reg, accumulate_reg, result;
   logic [3:0]        first_operand_num, second_operand_num, accumulate_num;
   logic [3:0]        dest_num, greater_equal_flags, result_dest_num;
   int                mismatches;
   int                num_checks;

   packed_unsigned_simd_alu uut (.clk, .rst_b, .op_valid, .op, .first_operand_reg,
      .second_operand_reg, .accumulate_reg, .first_operand_num, .second_operand_num,
      .accumulate_num, .dest_present, .dest_num, .greater_equal_flags, .result_valid,
      .result, .result_dest_num, .flags_write, .illegal_reg);
   pipeline_model pipe (.clk, .op_valid, .op, .first_operand_reg, .second_operand_reg,
      .accumulate_reg, .first_operand_num, .second_operand_num, .accumulate_num,
      .dest_present, .dest_num, .greater_equal_flags);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // reference arithmetic; 17 and 9 bit sums keep carry and borrow for halving
   function automatic logic [31:0] expect_of(input simd_alu_pkg::op_e o,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] c, input logic [3:0] g);
      logic [16:0] hi;
      logic [16:0] lo;
      logic [8:0]  d;
      logic [31:0] half8, sub8, sel, sad;
      sad = 32'h0;
      for (int i = 0; i < 4; i++) begin
         d = a[8*i+:8] - b[8*i+:8];
         half8[8*i+:8] = d[8:1];
         sub8[8*i+:8] = d[7:0];
         sel[8*i+:8] = g[i] ? a[8*i+:8] : b[8*i+:8];
         sad = sad + (d[8] ? b[8*i+:8] - a[8*i+:8] : d[7:0]);
      end
      hi = (o == simd_alu_pkg::OP_HALVING_ADD_SUB_EXCHANGE) ? a[31:16] + b[15:0] :
           (o == simd_alu_pkg::OP_HALVING_SUB_ADD_EXCHANGE) ? a[31:16] - b[15:0] :
           a[31:16] - b[31:16];
      lo = (o == simd_alu_pkg::OP_HALVING_ADD_SUB_EXCHANGE) ? a[15:0] - b[31:16] :
           (o == simd_alu_pkg::OP_HALVING_SUB_ADD_EXCHANGE) ? a[15:0] + b[31:16] :
           a[15:0] - b[15:0];
      case (o)
         simd_alu_pkg::OP_HALVING_SUB_BYTES:       return half8;
         simd_alu_pkg::OP_BYTE_SELECT:             return sel;
         simd_alu_pkg::OP_SUM_ABS_DIFF_BYTES:      return sad;
         simd_alu_pkg::OP_SUM_ABS_DIFF_ACCUMULATE: return sad + c;
         simd_alu_pkg::OP_UNSIGNED_SUB_HALFWORDS:  return {hi[15:0], lo[15:0]};
         simd_alu_pkg::OP_UNSIGNED_SUB_BYTES:      return sub8;
         default:                                  return {hi[16:1], lo[16:1]};
      endcase
   endfunction

   task automatic issue(input simd_alu_pkg::op_e o, input logic [31:0] a, input logic [31:0] b,
                        input logic [31:0] c, input logic [3:0] g, input logic [15:0] nums,
                        input logic dp);
      pipe.send(o, a, b, c, g, nums, dp);
      pipe.idle();
      #1;
   endtask

   task automatic sc_reset();
      repeat (10) @(posedge clk);
      check(result_valid, 1'b0);
      check(illegal_reg, 1'b0);
      check(result, 32'h0);
      check(result_dest_num, 4'h0);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      check(result_valid, 1'b0);
   endtask

   task automatic sc_mid_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      check(result, 32'h0);
      check(result_dest_num, 4'h0);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check(result_valid, 1'b0);
      issue(simd_alu_pkg::OP_SUM_ABS_DIFF_BYTES, 32'h0000_0003, 32'h0000_0001, 32'h0,
            4'h0, 16'h1234, 1'b1);
      check(result_valid, 1'b1);
      check(result, 32'h0000_0002);
   endtask

   task automatic sc_all_ops();
      logic [31:0] va [4] = '{32'hffff_0001, 32'h0000_0000, 32'h8040_2010, 32'h1234_5678};
      logic [31:0] vb [4] = '{32'h0001_ffff, 32'hffff_ffff, 32'h0102_7f80, 32'h9abc_def0};
      simd_alu_pkg::op_e o;
      for (int v = 0; v < 4; v++) begin
         for (int k = 0; k < 9; k++) begin
            o = simd_alu_pkg::op_e'(k);
            issue(o, va[v], vb[v], 32'hffff_ff00, 4'(v * 5 + 5), 16'h1234, 1'b1);
            check(result_valid, 1'b1);
            check(result, expect_of(o, va[v], vb[v], 32'hffff_ff00, 4'(v * 5 + 5)));
            check(flags_write, 1'b0);
            check({result_dest_num, illegal_reg}, 5'h08);
         end
      end
   endtask

   task automatic sc_dest();
      issue(simd_alu_pkg::OP_UNSIGNED_SUB_HALFWORDS, 32'h0, 32'h1, 32'h0, 4'h0, 16'h5239, 1'b0);
      check(result_dest_num, 4'h5);
      check(result, 32'h0000_ffff);
      issue(simd_alu_pkg::OP_UNSIGNED_SUB_HALFWORDS, 32'h0, 32'h1, 32'h0, 4'h0, 16'h5239, 1'b1);
      check(result_dest_num, 4'h9);
   endtask

   task automatic sc_illegal();
      logic [15:0] bad [3] = '{16'hd234, 16'h1f34, 16'h123d};
      for (int i = 0; i < 3; i++) begin
         issue(simd_alu_pkg::OP_UNSIGNED_SUB_BYTES, 32'h0102_0304, 32'h0403_0201, 32'h0,
               4'h0, bad[i], 1'b1);
         check(illegal_reg, 1'b1);
         check(result, 32'hfdff_0103);
      end
      issue(simd_alu_pkg::OP_BYTE_SELECT, 32'h0102_0304, 32'h0403_0201, 32'h0, 4'h6,
            16'hdfdf, 1'b1);
      check(illegal_reg, 1'b0);
      check(result, 32'h0402_0301);
   endtask

   task automatic sc_back_to_back();
      pipe.send(simd_alu_pkg::OP_HALVING_SUB_HALFWORDS, 32'h0000_ffff, 32'h0001_0000, 32'h0,
                4'h0, 16'h1234, 1'b1);
      pipe.send(simd_alu_pkg::OP_SUM_ABS_DIFF_ACCUMULATE, 32'h00ff_00ff, 32'hff00_ff00,
                32'h0000_0010, 4'h0, 16'h1234, 1'b1);
      #1;
      check(result, 32'hffff_7fff);
      pipe.idle();
      #1;
      check(result, 32'h0000_040c);
      @(posedge clk);
      #1;
      check(result_valid, 1'b0);
      check(result, 32'h0000_040c);
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      rst_b = 1'b0;
      mismatches = 0;
      num_checks = 0;
      pipe.park();
      sc_reset();
      sc_all_ops();
      sc_dest();
      sc_illegal();
      sc_back_to_back();
      sc_mid_reset();
      final_report();
   end

   // hang guard: the whole sequence needs far fewer cycles than this
   initial begin
      #1000000;
      mismatches++;
      final_report();
   end
endmodule // tb_packed_unsigned_simd_alu
